// ### include/rtsp_pkg.sv
// Ring protection switch constants
package rtsp_pkg;

    // Stream and frame layout
    localparam int          RTSP_DATA_W     = 8;
    localparam int          RTSP_POS_W      = 8;
    localparam int          RTSP_FRAME_LEN  = 66;
    localparam int          RTSP_GROUP_SLOTS = 8;
    localparam int          RTSP_APS_W      = 16;
    localparam logic [7:0]  RTSP_K1_POS     = 8'h00;
    localparam logic [7:0]  RTSP_K2_POS     = 8'h01;
    localparam logic [7:0]  RTSP_PAY_POS    = 8'h02;
    localparam logic [1:0]  RTSP_APS_ACCEPT = 2'h3;

    // Fill bytes
    localparam logic [7:0]  RTSP_AIS_BYTE   = 8'hFF;
    localparam logic [7:0]  RTSP_UNEQ_FILL  = 8'h00;
    localparam logic [7:0]  RTSP_UNEQ_PTR   = 8'h0A;

    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_SLOT_USE    = 8'h04;
    localparam logic [7:0]  OFS_SQUELCH     = 8'h08;
    localparam logic [7:0]  OFS_APS_TX      = 8'h0C;
    localparam logic [7:0]  OFS_APS_RX_W    = 8'h10;
    localparam logic [7:0]  OFS_APS_RX_E    = 8'h14;
    localparam logic [7:0]  OFS_STATE       = 8'h18;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h1C;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h20;

    // Control register fields
    localparam int          CTRL_FORCE_W    = 0;
    localparam int          CTRL_FORCE_E    = 1;
    localparam int          CTRL_AUTO       = 2;
    localparam int          CTRL_REPORT     = 3;
    localparam int          CTRL_SRC_W_LSB  = 4;
    localparam int          CTRL_SRC_E_LSB  = 6;
    localparam logic [31:0] CTRL_MASK       = 32'h0000_00FF;
    localparam logic [31:0] CTRL_RST        = 32'h0000_0004;

    // Other reset values
    localparam logic [15:0] SLOT_USE_RST    = 16'h0000;
    localparam logic [15:0] SQUELCH_RST     = 16'h0000;
    localparam logic [31:0] APS_TX_RST      = 32'h0000_0000;
    localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

    // Interrupt status bits
    localparam int          IRQ_W           = 4;
    localparam int          IRQ_APS_W       = 0;
    localparam int          IRQ_APS_E       = 1;
    localparam int          IRQ_FAIL_W      = 2;
    localparam int          IRQ_FAIL_E      = 3;

    // Protection output source
    typedef enum logic [1:0] {
        RTSP_SRC_UNEQ     = 2'b00,
        RTSP_SRC_EXTRA    = 2'b01,
        RTSP_SRC_WORK_OWN = 2'b11,
        RTSP_SRC_WORK_OPP = 2'b10
    } rtsp_src_e;

endpackage : rtsp_pkg

// ### rtl/rtsp_aps_rx.sv
// Signalling receiver
`timescale 1ns/1ns
module rtsp_aps_rx
    import rtsp_pkg::*;
(
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   k1_stb,
    input  wire logic                   k2_stb,
    input  wire logic [RTSP_DATA_W-1:0] data,
    output logic      [RTSP_APS_W-1:0]  aps,
    output logic                        aps_new
);

    logic [RTSP_DATA_W-1:0] k1_r;
    logic [RTSP_APS_W-1:0]  cand_r;
    logic [1:0]             cnt_r;
    logic [RTSP_APS_W-1:0]  aps_r;
    logic                   new_r;

    wire logic [RTSP_APS_W-1:0] value   = {k1_r, data};
    wire logic                  same    = (value == cand_r);
    wire logic [1:0]            cnt_nxt = !same ? 2'h1 :
                                          (cnt_r == RTSP_APS_ACCEPT) ? cnt_r : cnt_r + 2'h1;
    wire logic                  accept  = k2_stb && (cnt_nxt == RTSP_APS_ACCEPT)
                                          && (value != aps_r);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            k1_r   <= 8'h00;
            cand_r <= 16'h0000;
            cnt_r  <= 2'h0;
            aps_r  <= 16'h0000;
            new_r  <= 1'b0;
        end
        else
        begin
            new_r <= accept;
            if (k1_stb)
                k1_r <= data;
            if (k2_stb)
            begin
                cand_r <= value;
                cnt_r  <= cnt_nxt;
            end
            if (accept)
                aps_r <= value;
        end
    end

    assign aps     = aps_r;
    assign aps_new = new_r;

endmodule : rtsp_aps_rx

// ### rtl/rtsp_ring_switch.sv
// Ring protection switch
// Contract
// - Working B: own working A or opposite protection.
// - Working A output comes from its working B input.
// - Protection A: unequipped, extra or working B.
// - Unused protection slots: unequipped VC-4, valid pointer.
// - Misconnected protection slots get all-ones.
// - Unequipped insertion follows the path structure map.
// - Trail source passes data, clock, frame start.
// - Trail fail follows server fail; report is fail AND enable.
// - Outgoing payload alternates protection and working bytes, 8 slot pairs per side.
// - Outgoing signalling word goes into K1 and K2.
// - Incoming groups split; fail passes on, degrade only drives selection.
// - Sixteen signalling bits from K1 and K2.
// - New signalling value after three identical frames.
`timescale 1ns/1ns
module rtsp_ring_switch
    import rtsp_pkg::*;
#(
    parameter int FRAME_LEN = RTSP_FRAME_LEN
)
(
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic [31:0]                 hrdata,
    output logic                        hresp,
    output logic                        irq,
    input  wire logic                   ring_clk,
    input  wire logic                   ring_fs,
    input  wire logic [RTSP_DATA_W-1:0] a_w_rx_data,
    input  wire logic [RTSP_DATA_W-1:0] a_e_rx_data,
    input  wire logic                   server_fail_in_w,
    input  wire logic                   server_fail_in_e,
    input  wire logic                   server_degrade_in_w,
    input  wire logic                   server_degrade_in_e,
    output logic                        a_tx_clk,
    output logic                        a_tx_fs,
    output logic [RTSP_DATA_W-1:0]      a_w_tx_data,
    output logic [RTSP_DATA_W-1:0]      a_e_tx_data,
    input  wire logic [RTSP_DATA_W-1:0] b_w_work_in,
    input  wire logic [RTSP_DATA_W-1:0] b_e_work_in,
    input  wire logic [RTSP_DATA_W-1:0] b_w_extra_in,
    input  wire logic [RTSP_DATA_W-1:0] b_e_extra_in,
    output logic [RTSP_DATA_W-1:0]      b_w_work_out,
    output logic [RTSP_DATA_W-1:0]      b_e_work_out,
    output logic [RTSP_DATA_W-1:0]      b_w_prot_out,
    output logic [RTSP_DATA_W-1:0]      b_e_prot_out,
    output logic                        b_w_work_fail,
    output logic                        b_e_work_fail,
    output logic                        trail_fail_action_w,
    output logic                        trail_fail_action_e,
    output logic                        correlated_fail_report_w,
    output logic                        correlated_fail_report_e
);

    localparam int                    SYNC_W   = 6 + 6 * RTSP_DATA_W;
    localparam logic [RTSP_POS_W-1:0] POS_LAST = RTSP_POS_W'(FRAME_LEN - 1);

    // Outgoing line byte
    function automatic logic [RTSP_DATA_W-1:0] rtsp_tx_byte(
        input logic                   k1,
        input logic                   k2,
        input logic                   work,
        input logic                   ptr,
        input logic                   used,
        input logic                   squelch,
        input logic [1:0]             src,
        input logic [RTSP_APS_W-1:0]  aps,
        input logic [RTSP_DATA_W-1:0] work_own,
        input logic [RTSP_DATA_W-1:0] work_opp,
        input logic [RTSP_DATA_W-1:0] extra
    );
        logic [RTSP_DATA_W-1:0] b;
        b = ptr ? RTSP_UNEQ_PTR : RTSP_UNEQ_FILL;
        if (k1)
            b = aps[15:8];
        else if (k2)
            b = aps[7:0];
        else if (work)
            b = work_own;
        else if (squelch)
            b = RTSP_AIS_BYTE;
        else if (used)
        begin
            unique case (rtsp_src_e'(src))
                RTSP_SRC_UNEQ:     b = ptr ? RTSP_UNEQ_PTR : RTSP_UNEQ_FILL;
                RTSP_SRC_EXTRA:    b = extra;
                RTSP_SRC_WORK_OWN: b = work_own;
                RTSP_SRC_WORK_OPP: b = work_opp;
            endcase
        end
        return b;
    endfunction : rtsp_tx_byte

    // Input synchroniser
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    logic              clk_d_r;

    wire logic [SYNC_W-1:0] async_in = {ring_clk, ring_fs,
                                        server_fail_in_w, server_fail_in_e,
                                        server_degrade_in_w, server_degrade_in_e,
                                        a_w_rx_data, a_e_rx_data,
                                        b_w_work_in, b_e_work_in,
                                        b_w_extra_in, b_e_extra_in};

    wire logic                   clk_s   = sync2_r[SYNC_W-1];
    wire logic                   fs_s    = sync2_r[SYNC_W-2];
    wire logic                   sf_w_s  = sync2_r[SYNC_W-3];
    wire logic                   sf_e_s  = sync2_r[SYNC_W-4];
    wire logic                   sd_w_s  = sync2_r[SYNC_W-5];
    wire logic                   sd_e_s  = sync2_r[SYNC_W-6];
    wire logic [RTSP_DATA_W-1:0] aw_s    = sync2_r[6*RTSP_DATA_W-1 -: RTSP_DATA_W];
    wire logic [RTSP_DATA_W-1:0] ae_s    = sync2_r[5*RTSP_DATA_W-1 -: RTSP_DATA_W];
    wire logic [RTSP_DATA_W-1:0] bww_s   = sync2_r[4*RTSP_DATA_W-1 -: RTSP_DATA_W];
    wire logic [RTSP_DATA_W-1:0] bew_s   = sync2_r[3*RTSP_DATA_W-1 -: RTSP_DATA_W];
    wire logic [RTSP_DATA_W-1:0] bwx_s   = sync2_r[2*RTSP_DATA_W-1 -: RTSP_DATA_W];
    wire logic [RTSP_DATA_W-1:0] bex_s   = sync2_r[RTSP_DATA_W-1 -: RTSP_DATA_W];
    wire logic                   tick    = clk_s & ~clk_d_r;
    wire logic                   ftick   = ~clk_s & clk_d_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            clk_d_r <= 1'b0;
        end
        else
        begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
            clk_d_r <= clk_s;
        end
    end

    // Frame position counter
    logic [RTSP_POS_W-1:0] pos_r;

    wire logic [RTSP_POS_W-1:0] cur_pos  = fs_s ? '0 : pos_r;
    wire logic                  is_k1    = (cur_pos == RTSP_K1_POS);
    wire logic                  is_k2    = (cur_pos == RTSP_K2_POS);
    wire logic                  is_pay   = (cur_pos >= RTSP_PAY_POS);
    wire logic [RTSP_POS_W-1:0] pay_idx  = cur_pos - RTSP_PAY_POS;
    wire logic                  is_work  = is_pay & pay_idx[0];
    wire logic                  is_prot  = is_pay & ~pay_idx[0];
    wire logic [2:0]            pair     = pay_idx[3:1];
    wire logic                  ptr_row  = (pay_idx[RTSP_POS_W-1:4] == '0);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pos_r <= '0;
        else if (tick)
            pos_r <= (cur_pos == POS_LAST) ? '0 : cur_pos + 1'b1;
    end

    // Registers
    logic [31:0]            ctrl_r;
    logic [15:0]            slot_use_r;
    logic [15:0]            squelch_r;
    logic [31:0]            aps_tx_r;
    logic [IRQ_W-1:0]       irq_stat_r;
    logic [IRQ_W-1:0]       irq_mask_r;
    logic                   wr_pend_r;
    logic [7:0]             wr_addr_r;
    logic [31:0]            hrdata_r;
    logic                   irq_r;

    // Signalling receivers
    logic [RTSP_APS_W-1:0] aps_rx_w;
    logic [RTSP_APS_W-1:0] aps_rx_e;
    logic                  aps_new_w;
    logic                  aps_new_e;

    rtsp_aps_rx u_aps_rx_w (
        .hclk    (hclk),
        .hresetn (hresetn),
        .k1_stb  (tick & is_k1),
        .k2_stb  (tick & is_k2),
        .data    (aw_s),
        .aps     (aps_rx_w),
        .aps_new (aps_new_w)
    );

    rtsp_aps_rx u_aps_rx_e (
        .hclk    (hclk),
        .hresetn (hresetn),
        .k1_stb  (tick & is_k1),
        .k2_stb  (tick & is_k2),
        .data    (ae_s),
        .aps     (aps_rx_e),
        .aps_new (aps_new_e)
    );

    // Sink selection
    wire logic auto_en = ctrl_r[CTRL_AUTO];
    wire logic sel_w   = ctrl_r[CTRL_FORCE_W] | (auto_en & (sf_w_s | sd_w_s));
    wire logic sel_e   = ctrl_r[CTRL_FORCE_E] | (auto_en & (sf_e_s | sd_e_s));

    // Outgoing bytes
    wire logic [RTSP_DATA_W-1:0] tx_w = rtsp_tx_byte(is_k1, is_k2, is_work, ptr_row,
        slot_use_r[{1'b0, pair}],
        squelch_r[{1'b0, pair}],
        ctrl_r[CTRL_SRC_W_LSB +: 2],
        aps_tx_r[15:0], bww_s, bew_s, bwx_s);
    wire logic [RTSP_DATA_W-1:0] tx_e = rtsp_tx_byte(is_k1, is_k2, is_work, ptr_row,
        slot_use_r[{1'b1, pair}],
        squelch_r[{1'b1, pair}],
        ctrl_r[CTRL_SRC_E_LSB +: 2],
        aps_tx_r[31:16], bew_s, bww_s, bex_s);

    // Data path
    logic [RTSP_DATA_W-1:0] w_prot_hold_r;
    logic [RTSP_DATA_W-1:0] e_prot_hold_r;
    logic [RTSP_DATA_W-1:0] a_w_tx_r;
    logic [RTSP_DATA_W-1:0] a_e_tx_r;
    logic                   a_tx_clk_r;
    logic                   a_tx_fs_r;
    logic [RTSP_DATA_W-1:0] b_w_work_r;
    logic [RTSP_DATA_W-1:0] b_e_work_r;
    logic [RTSP_DATA_W-1:0] b_w_prot_r;
    logic [RTSP_DATA_W-1:0] b_e_prot_r;
    logic                   b_w_fail_r;
    logic                   b_e_fail_r;
    logic                   tfa_w_r;
    logic                   tfa_e_r;
    logic                   cfr_w_r;
    logic                   cfr_e_r;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            w_prot_hold_r <= '0;
            e_prot_hold_r <= '0;
            a_w_tx_r      <= '0;
            a_e_tx_r      <= '0;
            a_tx_fs_r     <= 1'b0;
            b_w_work_r    <= '0;
            b_e_work_r    <= '0;
            b_w_prot_r    <= '0;
            b_e_prot_r    <= '0;
        end
        else if (tick)
        begin
            a_w_tx_r  <= tx_w;
            a_e_tx_r  <= tx_e;
            a_tx_fs_r <= (cur_pos == '0);
            if (is_prot)
            begin
                w_prot_hold_r <= aw_s;
                e_prot_hold_r <= ae_s;
                b_w_prot_r    <= aw_s;
                b_e_prot_r    <= ae_s;
            end
            if (is_work)
            begin
                b_w_work_r <= sel_w ? e_prot_hold_r : aw_s;
                b_e_work_r <= sel_e ? w_prot_hold_r : ae_s;
            end
        end
    end

    // Outgoing line clock
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            a_tx_clk_r <= 1'b0;
        else if (ftick)
            a_tx_clk_r <= 1'b1;
        else if (tick)
            a_tx_clk_r <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tfa_w_r    <= 1'b0;
            tfa_e_r    <= 1'b0;
            cfr_w_r    <= 1'b0;
            cfr_e_r    <= 1'b0;
            b_w_fail_r <= 1'b0;
            b_e_fail_r <= 1'b0;
        end
        else
        begin
            tfa_w_r    <= sf_w_s;
            tfa_e_r    <= sf_e_s;
            cfr_w_r    <= sf_w_s & ctrl_r[CTRL_REPORT];
            cfr_e_r    <= sf_e_s & ctrl_r[CTRL_REPORT];
            b_w_fail_r <= sel_w ? sf_e_s : sf_w_s;
            b_e_fail_r <= sel_e ? sf_w_s : sf_e_s;
        end
    end

    // AHB-Lite slave, zero wait states
    wire logic       ahb_go  = hsel & htrans[1] & hready;
    wire logic [7:0] rd_ofs  = haddr[7:0];
    wire logic [7:0] wr_ofs  = wr_addr_r;
    wire logic [31:0] state_v = {26'h0, sd_e_s, sd_w_s, sf_e_s, sf_w_s, sel_e, sel_w};
    wire logic [31:0] rd_data =
        (rd_ofs == OFS_CTRL)     ? ctrl_r :
        (rd_ofs == OFS_SLOT_USE) ? {16'h0, slot_use_r} :
        (rd_ofs == OFS_SQUELCH)  ? {16'h0, squelch_r} :
        (rd_ofs == OFS_APS_TX)   ? aps_tx_r :
        (rd_ofs == OFS_APS_RX_W) ? {16'h0, aps_rx_w} :
        (rd_ofs == OFS_APS_RX_E) ? {16'h0, aps_rx_e} :
        (rd_ofs == OFS_STATE)    ? state_v :
        (rd_ofs == OFS_IRQ_STAT) ? {28'h0, irq_stat_r} :
        (rd_ofs == OFS_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0000_0000;

    wire logic [IRQ_W-1:0] irq_set = {sf_e_s & ~tfa_e_r, sf_w_s & ~tfa_w_r,
                                      aps_new_e, aps_new_w};
    wire logic [IRQ_W-1:0] irq_clr = (wr_pend_r && wr_ofs == OFS_IRQ_STAT) ?
                                     hwdata[IRQ_W-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_r <= ahb_go & hwrite;
            if (ahb_go)
                wr_addr_r <= haddr[7:0];
            if (ahb_go && !hwrite)
                hrdata_r <= rd_data;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ctrl_r     <= CTRL_RST;
            slot_use_r <= SLOT_USE_RST;
            squelch_r  <= SQUELCH_RST;
            aps_tx_r   <= APS_TX_RST;
            irq_mask_r <= IRQ_MASK_RST;
        end
        else if (wr_pend_r)
        begin
            if (wr_ofs == OFS_CTRL)
                ctrl_r <= hwdata & CTRL_MASK;
            if (wr_ofs == OFS_SLOT_USE)
                slot_use_r <= hwdata[15:0];
            if (wr_ofs == OFS_SQUELCH)
                squelch_r <= hwdata[15:0];
            if (wr_ofs == OFS_APS_TX)
                aps_tx_r <= hwdata;
            if (wr_ofs == OFS_IRQ_MASK)
                irq_mask_r <= hwdata[IRQ_W-1:0];
        end
    end

    // Sticky status, set wins over clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_stat_r <= '0;
            irq_r      <= 1'b0;
        end
        else
        begin
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
            irq_r      <= |(((irq_stat_r & ~irq_clr) | irq_set) & irq_mask_r);
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;
    assign irq = irq_r;
    assign a_tx_clk = a_tx_clk_r;
    assign a_tx_fs = a_tx_fs_r;
    assign a_w_tx_data = a_w_tx_r;
    assign a_e_tx_data = a_e_tx_r;
    assign b_w_work_out = b_w_work_r;
    assign b_e_work_out = b_e_work_r;
    assign b_w_prot_out = b_w_prot_r;
    assign b_e_prot_out = b_e_prot_r;
    assign b_w_work_fail = b_w_fail_r;
    assign b_e_work_fail = b_e_fail_r;
    assign trail_fail_action_w = tfa_w_r;
    assign trail_fail_action_e = tfa_e_r;
    assign correlated_fail_report_w = cfr_w_r;
    assign correlated_fail_report_e = cfr_e_r;

endmodule : rtsp_ring_switch

// ### verification/rtsp_sva.sv
// Switch assertions
`timescale 1ns/1ns
module rtsp_sva
    import rtsp_pkg::*;
(
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic                   ring_clk,
    input wire logic                   server_fail_in_w,
    input wire logic                   trail_fail_action_w,
    input wire logic                   correlated_fail_report_w,
    input wire logic                   a_tx_clk,
    input wire logic                   a_tx_fs,
    input wire logic [RTSP_DATA_W-1:0] a_w_tx_data
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_fail_up;
        $rose(server_fail_in_w);
    endsequence
    sequence s_line_up;
        $rose(ring_clk);
    endsequence
    chk_bus_zero_wait: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    chk_fail_rise: assert property (s_fail_up |-> ##[2:4] trail_fail_action_w)
        else $error("fail not followed");
    chk_fail_fall: assert property ($fell(server_fail_in_w) |-> ##[2:4] !trail_fail_action_w)
        else $error("fail not cleared");
    chk_report_gate: assert property (correlated_fail_report_w |->
        trail_fail_action_w || $past(trail_fail_action_w)) else $error("report without fail");
    chk_txclk_low: assert property (s_line_up |-> ##[1:5] !a_tx_clk)
        else $error("clock not low");
    chk_txclk_high: assert property ($fell(ring_clk) |-> ##[1:5] a_tx_clk)
        else $error("clock not high");
    chk_data_on_clk: assert property ($changed(a_w_tx_data) |-> !a_tx_clk)
        else $error("byte moved");
    chk_fs_on_clk: assert property ($changed(a_tx_fs) |-> !a_tx_clk)
        else $error("frame start moved");
endmodule : rtsp_sva

// ### verification/rtsp_line_model.sv
// Line-side partner
`timescale 1ns/1ns
module rtsp_line_model
    import rtsp_pkg::*;
#(
    parameter int FLEN = 34
)
(
    input  wire logic [15:0] aps_w,
    input  wire logic [15:0] aps_e,
    output logic             ring_clk,
    output logic             ring_fs,
    output logic [7:0]       a_w_rx_data,
    output logic [7:0]       a_e_rx_data
);
    int pos = FLEN - 1;
    initial
    begin
        ring_clk = 1'b0;
        ring_fs = 1'b0;
        a_w_rx_data = 8'h00;
        a_e_rx_data = 8'h00;
        #13;
        forever #200 ring_clk = ~ring_clk;
    end
    // Bytes move at the falling edge
    always @(negedge ring_clk)
    begin
        pos = (pos + 1) % FLEN;
        ring_fs = (pos == 0);
        a_w_rx_data = pos == 0 ? aps_w[15:8] : pos == 1 ? aps_w[7:0] : 8'(pos);
        a_e_rx_data = pos == 0 ? aps_e[15:8] : pos == 1 ? aps_e[7:0] : 8'(pos) | 8'h80;
    end
endmodule : rtsp_line_model

// ### verification/tb.sv
// Switch bench
`timescale 1ns/1ns
module tb
    import rtsp_pkg::*;
();
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic        hreadyout, hresp, irq, ring_clk, ring_fs, a_tx_clk, a_tx_fs;
    logic        server_fail_in_w = 1'b0, server_fail_in_e = 1'b0;
    logic        server_degrade_in_w = 1'b0, server_degrade_in_e = 1'b0;
    logic        trail_fail_action_w, trail_fail_action_e, correlated_fail_report_w, b_w_work_fail;
    logic [7:0]  a_w_rx_data, a_e_rx_data, a_w_tx_data, a_e_tx_data;
    logic [7:0]  b_w_work_out, b_e_work_out, b_w_prot_out;
    logic [7:0]  b_w_work_in = 8'h5A, b_e_work_in = 8'hC3;
    logic [7:0]  b_w_extra_in = 8'h3C, b_e_extra_in = 8'h66;
    logic [15:0] aps_w = 16'h0000;
    int          err_total = 0, n_compared = 0, cyc = 0;

    always #25 hclk = ~hclk;
    rtsp_line_model #(.FLEN(34)) i_line (.aps_w, .aps_e(16'h0000), .ring_clk, .ring_fs,
        .a_w_rx_data, .a_e_rx_data);
    rtsp_ring_switch #(.FRAME_LEN(34)) i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .irq, .ring_clk,
        .ring_fs, .a_w_rx_data, .a_e_rx_data, .server_fail_in_w, .server_fail_in_e,
        .server_degrade_in_w, .server_degrade_in_e, .a_tx_clk, .a_tx_fs, .a_w_tx_data,
        .a_e_tx_data, .b_w_work_in, .b_e_work_in, .b_w_extra_in, .b_e_extra_in, .b_w_work_out,
        .b_e_work_out, .b_w_prot_out, .b_e_prot_out(), .b_w_work_fail, .b_e_work_fail(),
        .trail_fail_action_w, .trail_fail_action_e, .correlated_fail_report_w,
        .correlated_fail_report_e());

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h000000, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    task automatic at_pos(input int p);
        @(posedge a_tx_clk iff a_tx_fs === 1'b1);
        repeat (p) @(posedge a_tx_clk);
    endtask : at_pos

    task automatic t_regs;
        rdchk(OFS_CTRL, CTRL_RST);
        rdchk(OFS_SLOT_USE, 32'h0);
        rdchk(OFS_IRQ_MASK, 32'h0);
        rdchk(8'h24, 32'h0);
        ahb(1'b1, OFS_CTRL, 32'hFFFF_FFFF);
        rdchk(OFS_CTRL, CTRL_MASK);
        ahb(1'b1, OFS_CTRL, CTRL_RST);
        $display("test regs done");
    endtask : t_regs
    task automatic t_aps;
        ahb(1'b1, OFS_APS_TX, 32'h1E2D_A55A);
        @(posedge ring_fs);
        @(posedge ring_clk);
        aps_w = 16'hC33C;
        repeat (2) @(posedge ring_fs);
        repeat (4) @(posedge ring_clk);
        rdchk(OFS_APS_RX_W, 32'h0);
        @(posedge ring_fs);
        repeat (4) @(posedge ring_clk);
        rdchk(OFS_APS_RX_W, 32'h0000_C33C);
        rdchk(OFS_IRQ_STAT, 32'h1);
        at_pos(0);
        chk({a_w_tx_data, a_e_tx_data}, 16'hA51E);
        @(posedge a_tx_clk);
        chk({a_w_tx_data, a_e_tx_data}, 16'h5A2D);
        $display("test aps done");
    endtask : t_aps
    task automatic t_fail;
        ahb(1'b1, OFS_IRQ_STAT, 32'hF);
        ahb(1'b1, OFS_IRQ_MASK, 32'h4);
        ahb(1'b1, OFS_CTRL, 32'hC);
        server_fail_in_w <= 1'b1;
        repeat (5) @(posedge hclk);
        chk({trail_fail_action_w, correlated_fail_report_w, b_w_work_fail, irq}, 4'hD);
        server_fail_in_e <= 1'b1;
        repeat (4) @(posedge hclk);
        rdchk(OFS_STATE, 32'hF);
        chk({b_w_work_fail, trail_fail_action_e}, 2'h3);
        ahb(1'b1, OFS_CTRL, CTRL_RST);
        repeat (4) @(posedge hclk);
        chk(correlated_fail_report_w, 1'b0);
        server_fail_in_w <= 1'b0;
        server_fail_in_e <= 1'b0;
        server_degrade_in_w <= 1'b1;
        server_degrade_in_e <= 1'b1;
        repeat (4) @(posedge hclk);
        rdchk(OFS_STATE, 32'h33);
        server_degrade_in_w <= 1'b0;
        server_degrade_in_e <= 1'b0;
        ahb(1'b1, OFS_IRQ_STAT, 32'hF);
        rdchk(OFS_IRQ_STAT, 32'h0);
        chk(irq, 1'b0);
        $display("test fail done");
    endtask : t_fail
    task automatic t_prot;
        logic [7:0] ew [4] = '{8'h0A, 8'h3C, 8'hC3, 8'h5A};
        logic [7:0] ee [4] = '{8'h0A, 8'h66, 8'h5A, 8'hC3};
        ahb(1'b1, OFS_SLOT_USE, 32'hFFFF);
        for (int s = 0; s < 4; s++)
        begin
            ahb(1'b1, OFS_CTRL, 32'h4 | (32'(s) << 4) | (32'(s) << 6));
            at_pos(2);
            chk({a_w_tx_data, a_e_tx_data}, {ew[s], ee[s]});
        end
        @(posedge a_tx_clk);
        chk({a_w_tx_data, a_e_tx_data}, 16'h5AC3);
        ahb(1'b1, OFS_SLOT_USE, 32'h0);
        at_pos(18);
        chk(a_w_tx_data, RTSP_UNEQ_FILL);
        ahb(1'b1, OFS_SQUELCH, 32'hFFFF);
        at_pos(2);
        chk({a_w_tx_data, a_e_tx_data}, 16'hFFFF);
        ahb(1'b1, OFS_SQUELCH, 32'h0);
        $display("test prot done");
    endtask : t_prot
    task automatic t_sel;
        ahb(1'b1, OFS_CTRL, CTRL_RST);
        at_pos(10);
        chk({b_w_work_out[7], b_w_work_out[0], b_e_work_out[7], b_e_work_out[0]}, 4'h7);
        chk({b_w_prot_out[7], b_w_prot_out[0]}, 2'h0);
        ahb(1'b1, OFS_CTRL, 32'h5);
        at_pos(10);
        chk({b_w_work_out[7], b_w_work_out[0]}, 2'h2);
        $display("test sel done");
    endtask : t_sel

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            results();
        end
    end
    initial
    begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_aps();
        t_fail();
        t_prot();
        t_sel();
        results();
    end
endmodule : tb

bind rtsp_ring_switch rtsp_sva i_sva (.hclk, .hresetn, .hreadyout, .hresp, .ring_clk,
    .server_fail_in_w, .trail_fail_action_w, .correlated_fail_report_w, .a_tx_clk, .a_tx_fs,
    .a_w_tx_data);
